// >>> sfp_prog_entry.sv
/*
  Serial programming entry and link for the code flash.
  Assumes clk is the internal fast oscillator clock; pins arrive asynchronous.
*/
`timescale 1ns/1ns
module sfp_prog_entry #(
  parameter int FIFO_DEPTH = sfp_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic mode_select_line,
  input wire logic prog_rx_pin,
  output logic prog_tx_pin,
  input wire logic sw_in,
  output logic sw_out,
  output logic sw_oe,
  input wire logic [1:0] rate_sel,
  output logic prog_mode,
  output logic normal_mode,
  output logic single_wire_link,
  output logic pin_hold_reset,
  output logic clk_src_internal,
  output logic [7:0] rx_data,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire logic [7:0] tx_data,
  input wire logic tx_valid,
  output logic tx_ready,
  output logic overrun,
  output logic frame_err,
  input wire logic err_clr
);
  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic ms_s1_q, ms_s2_q, rx_s1_q, rx_s2_q, sw_s1_q, sw_s2_q, sw_prev_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ms_s1_q <= 1'b1;
      ms_s2_q <= 1'b1;
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
      sw_s1_q <= 1'b1;
      sw_s2_q <= 1'b1;
      sw_prev_q <= 1'b1;
    end else begin
      ms_s1_q <= mode_select_line;
      ms_s2_q <= ms_s1_q;
      rx_s1_q <= prog_rx_pin;
      rx_s2_q <= rx_s1_q;
      sw_s1_q <= sw_in;
      sw_s2_q <= sw_s1_q;
      sw_prev_q <= sw_s2_q;
    end
  end

  // ----------------------------------------
  // Mode selection
  // ----------------------------------------
  typedef enum logic [2:0] {ST_SETTLE = 3'b001, ST_NORMAL = 3'b010, ST_PROG = 3'b100} sfp_mode_t;
  sfp_mode_t st_q, st_d;
  logic [1:0] settle_q, settle_d;
  logic single_q, single_d;
  logic sw_fall;

  assign sw_fall = sw_prev_q && !sw_s2_q;

  always_comb begin
    st_d = st_q;
    settle_d = settle_q;
    single_d = single_q;
    case (st_q)
      ST_SETTLE: begin
        // Mode line sampled once, after it has crossed both flops
        if (settle_q == sfp_pkg::SETTLE_CYCLES) begin
          st_d = ms_s2_q ? ST_NORMAL : ST_PROG;
        end else begin
          settle_d = settle_q + 1'b1;
        end
      end
      ST_NORMAL: begin
        // Start bit from a programmer on the single wire
        if (sw_fall) begin
          st_d = ST_PROG;
          single_d = 1'b1;
        end
      end
      ST_PROG: st_d = ST_PROG;
      default: st_d = ST_SETTLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= ST_SETTLE;
      settle_q <= 2'h0;
      single_q <= 1'b0;
    end else begin
      st_q <= st_d;
      settle_q <= settle_d;
      single_q <= single_d;
    end
  end

  assign prog_mode = (st_q == ST_PROG);
  assign normal_mode = (st_q == ST_NORMAL);
  assign single_wire_link = single_q;
  // Other pins stay at their reset state while programming
  assign pin_hold_reset = prog_mode;
  // Crystal path unused while programming
  assign clk_src_internal = prog_mode;

  // ----------------------------------------
  // Bit rate
  // ----------------------------------------
  logic [7:0] div;

  always_comb begin
    case (rate_sel)
      sfp_pkg::RSEL_1M: div = sfp_pkg::DIV_1M;
      sfp_pkg::RSEL_500K: div = sfp_pkg::DIV_500K;
      sfp_pkg::RSEL_250K: div = sfp_pkg::DIV_250K;
      sfp_pkg::RSEL_115K2: div = sfp_pkg::DIV_115K2;
      default: div = sfp_pkg::DIV_115K2;
    endcase
  end

  // ----------------------------------------
  // Receive path
  // ----------------------------------------
  logic rx_line, rxb_valid, rxb_ferr;
  logic [7:0] rxb_data;
  logic ovr_q, ovr_d, ferr_q, ferr_d;
  sfp_fifo_if #(.W(sfp_pkg::DATA_W)) fq ();

  assign rx_line = single_q ? sw_s2_q : rx_s2_q;

  sfp_uart_rx u_rx (
    .clk(clk),
    .rst(rst),
    .en(prog_mode),
    .rx(rx_line),
    .div(div),
    .data(rxb_data),
    .valid(rxb_valid),
    .frame_err(rxb_ferr)
  );

  sfp_fifo #(.W(sfp_pkg::DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .rst(rst),
    .f(fq)
  );

  assign fq.wr_valid = rxb_valid;
  assign fq.wr_data = rxb_data;
  assign fq.rd_ready = rx_ready;
  assign rx_data = fq.rd_data;
  assign rx_valid = fq.rd_valid;

  // The wire cannot be paused, so a full FIFO drops the byte and flags it
  always_comb begin
    ovr_d = (rxb_valid && !fq.wr_ready) ? 1'b1 : (err_clr ? 1'b0 : ovr_q);
    ferr_d = rxb_ferr ? 1'b1 : (err_clr ? 1'b0 : ferr_q);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ovr_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      ovr_q <= ovr_d;
      ferr_q <= ferr_d;
    end
  end

  assign overrun = ovr_q;
  assign frame_err = ferr_q;

  // ----------------------------------------
  // Transmit path
  // ----------------------------------------
  logic [9:0] tsh_q, tsh_d;
  logic [3:0] tbit_q, tbit_d;
  logic [7:0] ttick_q, ttick_d;
  logic tbusy_q, tbusy_d, tline_q, tline_d;

  // Half duplex on the single wire: no send while the synchronised wire is low
  assign tx_ready = prog_mode && !tbusy_q && !(single_q && !sw_s2_q);

  always_comb begin
    tsh_d = tsh_q;
    tbit_d = tbit_q;
    ttick_d = ttick_q;
    tbusy_d = tbusy_q;
    tline_d = tline_q;
    if (!tbusy_q) begin
      if (tx_valid && tx_ready) begin
        tsh_d = {1'b1, tx_data, 1'b0};
        tbusy_d = 1'b1;
        tbit_d = 4'h0;
        ttick_d = div - 1'b1;
        tline_d = 1'b0;
      end
    end else if (ttick_q == 8'h00) begin
      tbit_d = tbit_q + 1'b1;
      ttick_d = div - 1'b1;
      if (tbit_q == 4'(sfp_pkg::FRAME_BITS - 1)) begin
        tbusy_d = 1'b0;
        tline_d = 1'b1;
      end else begin
        tline_d = tsh_q[tbit_q + 1'b1];
      end
    end else begin
      ttick_d = ttick_q - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tsh_q <= 10'h3ff;
      tbit_q <= 4'h0;
      ttick_q <= 8'h00;
      tbusy_q <= 1'b0;
      tline_q <= 1'b1;
    end else begin
      tsh_q <= tsh_d;
      tbit_q <= tbit_d;
      ttick_q <= ttick_d;
      tbusy_q <= tbusy_d;
      tline_q <= tline_d;
    end
  end

  // Dedicated pin idles high when the single wire carries the link
  assign prog_tx_pin = single_q ? 1'b1 : tline_q;
  assign sw_out = tline_q;
  assign sw_oe = single_q && tbusy_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Start bit length, counted rather than unrolled
  logic [7:0] sb_cnt_q, sb_cnt_d;

  always_comb begin
    sb_cnt_d = (tbusy_q && tbit_q == 4'h0) ? sb_cnt_q + 8'h01 : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sb_cnt_q <= 8'h00;
    end else begin
      sb_cnt_q <= sb_cnt_d;
    end
  end

  sequence s_settled_high;
    (st_q == ST_SETTLE) && (settle_q == sfp_pkg::SETTLE_CYCLES) && ms_s2_q;
  endsequence

  sequence s_settled_low;
    (st_q == ST_SETTLE) && (settle_q == sfp_pkg::SETTLE_CYCLES) && !ms_s2_q;
  endsequence

  property p_high_normal;
    @(posedge clk) disable iff (rst) s_settled_high |=> normal_mode ##1 !prog_mode;
  endproperty
  a_high_normal: assert property (p_high_normal) else $error("high mode line did not give normal mode");

  property p_low_prog;
    @(posedge clk) disable iff (rst) s_settled_low |=> prog_mode [*3];
  endproperty
  a_low_prog: assert property (p_low_prog) else $error("low mode line did not give programming mode");

  property p_mode_holds;
    @(posedge clk) disable iff (rst) prog_mode |=> prog_mode && $stable(single_q);
  endproperty
  a_mode_holds: assert property (p_mode_holds) else $error("programming mode left before reset");

  property p_pins_held;
    @(posedge clk) disable iff (rst) pin_hold_reset == prog_mode && !(prog_mode && normal_mode);
  endproperty
  a_pins_held: assert property (p_pins_held) else $error("pin hold differs from mode");

  property p_int_clk;
    @(posedge clk) disable iff (rst) $rose(prog_mode) |-> clk_src_internal;
  endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal clock not selected");

  property p_wire_wake;
    @(posedge clk) disable iff (rst) (normal_mode && sw_fall) |=> prog_mode && single_wire_link;
  endproperty
  a_wire_wake: assert property (p_wire_wake) else $error("single-wire traffic did not enter programming");

  property p_start_bit;
    @(posedge clk) disable iff (rst)
      (tbusy_q && tbit_q == 4'h0 && ttick_q == 8'h00 && !single_q)
      |-> !prog_tx_pin && (sb_cnt_q == div - 8'h01);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit shorter than one bit time");

  property p_wire_quiet;
    @(posedge clk) disable iff (rst) !single_wire_link |-> !sw_oe;
  endproperty
  a_wire_quiet: assert property (p_wire_quiet) else $error("single wire driven on dedicated link");
endmodule // sfp_prog_entry

// >>> sfp_pkg.sv
/*
  Constants shared by the serial programming entry block: clock rate,
  link rates, bit period counts, rate selector codes, entry timing.
  Assumes a single 25 MHz clock from the internal fast oscillator.
*/
package sfp_pkg;
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned RATE_1M_BPS = 1_000_000;
  localparam int unsigned RATE_500K_BPS = 500_000;
  localparam int unsigned RATE_250K_BPS = 250_000;
  localparam int unsigned RATE_115K2_BPS = 115_200;
  localparam int unsigned DIV_W = 8;
  // Bit periods in clocks, rounded down
  localparam logic [7:0] DIV_1M = 8'(CLK_HZ / RATE_1M_BPS);
  localparam logic [7:0] DIV_500K = 8'(CLK_HZ / RATE_500K_BPS);
  localparam logic [7:0] DIV_250K = 8'(CLK_HZ / RATE_250K_BPS);
  localparam logic [7:0] DIV_115K2 = 8'(CLK_HZ / RATE_115K2_BPS);
  localparam logic [1:0] RSEL_1M = 2'h0;
  localparam logic [1:0] RSEL_500K = 2'h1;
  localparam logic [1:0] RSEL_250K = 2'h2;
  localparam logic [1:0] RSEL_115K2 = 2'h3;
  // Clocks after reset release before the synchronised mode line is valid
  localparam logic [1:0] SETTLE_CYCLES = 2'h2;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned FIFO_DEPTH = 8;
  localparam int unsigned DATA_W = 8;
endpackage

// >>> sfp_fifo_if.sv
/*
  Carrier between the entry block and its receive FIFO.
  Assumes both ends on the same clock.
*/
`timescale 1ns/1ns
interface sfp_fifo_if #(parameter int W = 8);
  logic wr_valid;
  logic wr_ready;
  logic [W-1:0] wr_data;
  logic rd_valid;
  logic rd_ready;
  logic [W-1:0] rd_data;
  modport fill (output wr_valid, output wr_data, input wr_ready,
                input rd_valid, input rd_data, output rd_ready);
  modport store (input wr_valid, input wr_data, output wr_ready,
                 output rd_valid, output rd_data, input rd_ready);
endinterface

// >>> sfp_fifo.sv
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock; rd_data is the head entry, registered storage.
*/
`timescale 1ns/1ns
module sfp_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic rst,
  sfp_fifo_if.store f
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  assign f.wr_ready = (cnt_q != (AW+1)'(DEPTH));
  assign f.rd_valid = (cnt_q != '0);
  assign f.rd_data = mem_q[rp_q];
  assign push = f.wr_valid && f.wr_ready;
  assign pop = f.rd_valid && f.rd_ready;

  always_comb begin
    wp_d = push ? ((wp_q == AW'(DEPTH-1)) ? '0 : wp_q + 1'b1) : wp_q;
    rp_d = pop ? ((rp_q == AW'(DEPTH-1)) ? '0 : rp_q + 1'b1) : rp_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      wp_q <= wp_d;
      rp_q <= rp_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wp_q] <= f.wr_data;
    end
  end

  property p_no_overfill;
    @(posedge clk) disable iff (rst) cnt_q <= (AW+1)'(DEPTH);
  endproperty
  a_no_overfill: assert property (p_no_overfill) else $error("fifo count above depth");
endmodule // sfp_fifo

// >>> sfp_uart_rx.sv
/*
  8N1 UART receiver for the programming link.
  Assumes rx is already synchronised and div is the bit period in clocks.
*/
`timescale 1ns/1ns
module sfp_uart_rx (
  input wire logic clk,
  input wire logic rst,
  input wire logic en,
  input wire logic rx,
  input wire logic [7:0] div,
  output logic [7:0] data,
  output logic valid,
  output logic frame_err
);
  typedef enum logic [2:0] {RX_IDLE = 3'b001, RX_BITS = 3'b010, RX_STOP = 3'b100} sfp_rx_st_t;
  sfp_rx_st_t st_q, st_d;
  // One bit wider: a bit and a half at the slowest rate exceeds 8 bits
  logic [8:0] tick_q, tick_d;
  logic [7:0] sh_q, sh_d;
  logic [2:0] bit_q, bit_d;
  logic valid_q, valid_d, ferr_q, ferr_d;

  always_comb begin
    st_d = st_q;
    tick_d = tick_q;
    sh_d = sh_q;
    bit_d = bit_q;
    valid_d = 1'b0;
    ferr_d = 1'b0;
    case (st_q)
      RX_IDLE: begin
        // Wait half a bit plus one bit to land in the middle of bit 0
        if (en && !rx) begin
          st_d = RX_BITS;
          tick_d = {1'b0, div} + {2'b00, div[7:1]};
          bit_d = '0;
        end
      end
      RX_BITS: begin
        if (tick_q == 9'h000) begin
          sh_d = {rx, sh_q[7:1]};
          // Sample spacing of exactly div clocks
          tick_d = {1'b0, div} - 9'h001;
          bit_d = bit_q + 1'b1;
          if (bit_q == 3'h7) begin
            st_d = RX_STOP;
          end
        end else begin
          tick_d = tick_q - 1'b1;
        end
      end
      RX_STOP: begin
        if (tick_q == 9'h000) begin
          valid_d = rx;
          ferr_d = !rx;
          st_d = RX_IDLE;
        end else begin
          tick_d = tick_q - 1'b1;
        end
      end
      default: st_d = RX_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= RX_IDLE;
      tick_q <= 9'h000;
      sh_q <= 8'h00;
      bit_q <= 3'h0;
      valid_q <= 1'b0;
      ferr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      tick_q <= tick_d;
      sh_q <= sh_d;
      bit_q <= bit_d;
      valid_q <= valid_d;
      ferr_q <= ferr_d;
    end
  end

  assign data = sh_q;
  assign valid = valid_q;
  assign frame_err = ferr_q;

  property p_rx_pulse;
    @(posedge clk) disable iff (rst) valid_q |=> !valid_q;
  endproperty
  a_rx_pulse: assert property (p_rx_pulse) else $error("receive strobe longer than one cycle");
endmodule // sfp_uart_rx

// >>> sfp_host_model.sv
/*
  Behavioural programming host for the serial programming entry block:
  an 8N1 sender and receiver for the dedicated pins and the single wire.
  Assumes the bench's clock and bit periods given in clock cycles.
*/
`timescale 1ns/1ns
module sfp_host_model (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic sw_wire,
  output logic rx_line,
  output logic sw_drv
);
  // ----------------------------------------
  // Line idle state
  // ----------------------------------------
  initial begin
    rx_line = 1'b1;
    sw_drv = 1'b1;
  end

  // ----------------------------------------
  // Frame sender, LSB first; stop_ok low gives a bad stop bit
  // ----------------------------------------
  task automatic send(input logic sel, input logic [7:0] data, input logic [7:0] div, input logic stop_ok);
    logic [9:0] frame;
    frame = {stop_ok, data, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      if (sel) sw_drv <= frame[i];
      else rx_line <= frame[i];
      repeat (int'(div) - 1) @(posedge clk);
    end
    @(posedge clk);
    rx_line <= 1'b1;
    sw_drv <= 1'b1;
  endtask

  // ----------------------------------------
  // Frame receiver, mid-bit sampling
  // ----------------------------------------
  task automatic recv(input logic sel, input logic [7:0] div, output logic [7:0] data, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    data = 8'h00;
    // Bounded so a silent device cannot hang the run
    while ((sel ? sw_wire : tx_line) !== 1'b0 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    if (n < 4000) begin
      repeat (int'(div) / 2) @(negedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (int'(div)) @(negedge clk);
        data[i] = sel ? sw_wire : tx_line;
      end
      repeat (int'(div)) @(negedge clk);
      ok = (sel ? sw_wire : tx_line) === 1'b1;
    end
  endtask
endmodule // sfp_host_model

// >>> sfp_prog_entry_tb_top.sv
/*
  Self-checking bench for the serial programming entry block.
  Assumes the host model drives the link pins and the bench owns reset.
*/
`timescale 1ns/1ns
module sfp_prog_entry_tb_top;
  logic clk, rst, mode_select_line, prog_rx_pin, prog_tx_pin, sw_in, sw_out, sw_oe, sw_drv;
  logic prog_mode, normal_mode, single_wire_link, pin_hold_reset, clk_src_internal;
  logic [1:0] rate_sel;
  logic [7:0] rx_data, tx_data;
  logic rx_valid, rx_ready, tx_valid, tx_ready, overrun, frame_err, err_clr;
  int failures, checks, cycles;

  // ----------------------------------------
  // Instances and single-wire resolution
  // ----------------------------------------
  assign sw_in = sw_oe ? sw_out : sw_drv;

  sfp_prog_entry sfp_prog_entry_inst (.clk(clk), .rst(rst), .mode_select_line(mode_select_line),
    .prog_rx_pin(prog_rx_pin), .prog_tx_pin(prog_tx_pin), .sw_in(sw_in), .sw_out(sw_out), .sw_oe(sw_oe),
    .rate_sel(rate_sel), .prog_mode(prog_mode), .normal_mode(normal_mode), .single_wire_link(single_wire_link),
    .pin_hold_reset(pin_hold_reset), .clk_src_internal(clk_src_internal), .rx_data(rx_data),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
    .overrun(overrun), .frame_err(frame_err), .err_clr(err_clr));

  sfp_host_model sfp_host_model_inst (.clk(clk), .tx_line(prog_tx_pin), .sw_wire(sw_in),
    .rx_line(prog_rx_pin), .sw_drv(sw_drv));

  // ----------------------------------------
  // Clock, timeout, report
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic final_report;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      $display("CHECK FAILED at %0t: run timed out", $time);
      final_report();
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [7:0] div_of(input logic [1:0] r);
    case (r)
      sfp_pkg::RSEL_1M: return sfp_pkg::DIV_1M;
      sfp_pkg::RSEL_500K: return sfp_pkg::DIV_500K;
      sfp_pkg::RSEL_250K: return sfp_pkg::DIV_250K;
      default: return sfp_pkg::DIV_115K2;
    endcase
  endfunction

  // Only the bench asserts reset; the mode line is set before release
  task automatic reset_to(input logic prog, input logic [1:0] rsel);
    @(posedge clk);
    rst <= 1'b1;
    mode_select_line <= !prog;
    rate_sel <= rsel;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    mode_select_line <= 1'b1;
    repeat (2) @(negedge clk);
  endtask

  task automatic pop_chk(input logic [7:0] exp);
    int n;
    n = 0;
    @(negedge clk);
    while (rx_valid !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    chk(rx_valid, 1'b1);
    chk(rx_data, exp);
    @(posedge clk);
    rx_ready <= 1'b1;
    @(posedge clk);
    rx_ready <= 1'b0;
  endtask

  task automatic send_tx(input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    tx_data <= d;
    tx_valid <= 1'b1;
    do begin
      @(negedge clk);
      n++;
    end while (tx_ready !== 1'b1 && n < 4000);
    @(posedge clk);
    tx_valid <= 1'b0;
  endtask

  task automatic tx_round(input logic sel, input logic [7:0] d, input logic [7:0] div);
    logic [7:0] got;
    logic ok;
    fork
      send_tx(d);
      sfp_host_model_inst.recv(sel, div, got, ok);
    join
    chk(got, d);
    chk(ok, 1'b1);
  endtask

  task automatic pulse_clr;
    @(posedge clk);
    err_clr <= 1'b1;
    @(posedge clk);
    err_clr <= 1'b0;
    @(negedge clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_normal;
    reset_to(1'b0, sfp_pkg::RSEL_1M);
    chk(normal_mode, 1'b1);
    chk(prog_mode, 1'b0);
    chk(pin_hold_reset, 1'b0);
    chk(clk_src_internal, 1'b0);
    chk(tx_ready, 1'b0);
    // Late low level on the mode line must not switch modes
    @(posedge clk);
    mode_select_line <= 1'b0;
    sfp_host_model_inst.send(1'b0, 8'h3c, sfp_pkg::DIV_1M, 1'b1);
    repeat (10) @(negedge clk);
    chk(prog_mode, 1'b0);
    chk(normal_mode, 1'b1);
    chk(rx_valid, 1'b0);
    @(posedge clk);
    mode_select_line <= 1'b1;
    $display("test normal done");
  endtask

  task automatic t_entry;
    reset_to(1'b1, sfp_pkg::RSEL_1M);
    chk(prog_mode, 1'b1);
    chk(normal_mode, 1'b0);
    chk(pin_hold_reset, 1'b1);
    chk(clk_src_internal, 1'b1);
    chk(prog_tx_pin, 1'b1);
    chk(sw_oe, 1'b0);
    chk(single_wire_link, 1'b0);
    $display("test entry done");
  endtask

  task automatic t_rates;
    logic [7:0] d;
    for (int i = 0; i < 4; i++) begin
      reset_to(1'b1, 2'(i));
      d = div_of(2'(i));
      sfp_host_model_inst.send(1'b0, 8'h5a ^ 8'(i), d, 1'b1);
      pop_chk(8'h5a ^ 8'(i));
      tx_round(1'b0, 8'ha5 + 8'(i), d);
    end
    $display("test rates done");
  endtask

  task automatic t_fifo;
    reset_to(1'b1, sfp_pkg::RSEL_1M);
    // Back-to-back bytes with the consumer stalled; the ninth is dropped
    for (int i = 0; i < 9; i++) sfp_host_model_inst.send(1'b0, 8'h10 + 8'(i), sfp_pkg::DIV_1M, 1'b1);
    repeat (20) @(negedge clk);
    chk(overrun, 1'b1);
    for (int i = 0; i < 8; i++) pop_chk(8'h10 + 8'(i));
    @(negedge clk);
    chk(rx_valid, 1'b0);
    pulse_clr();
    chk(overrun, 1'b0);
    $display("test fifo done");
  endtask

  task automatic t_frame;
    reset_to(1'b1, sfp_pkg::RSEL_1M);
    sfp_host_model_inst.send(1'b0, 8'h81, sfp_pkg::DIV_1M, 1'b0);
    repeat (20) @(negedge clk);
    chk(frame_err, 1'b1);
    // Let any phantom frame from the low stop bit finish first
    repeat (300) @(negedge clk);
    pulse_clr();
    chk(frame_err, 1'b0);
    $display("test frame done");
  endtask

  task automatic t_single;
    reset_to(1'b0, sfp_pkg::RSEL_250K);
    sfp_host_model_inst.send(1'b1, 8'hc3, sfp_pkg::DIV_250K, 1'b1);
    chk(prog_mode, 1'b1);
    chk(single_wire_link, 1'b1);
    pop_chk(8'hc3);
    tx_round(1'b1, 8'h96, sfp_pkg::DIV_250K);
    chk(prog_tx_pin, 1'b1);
    $display("test single done");
  endtask

  // ----------------------------------------
  // Main sequence: lines, entry, transfers, end
  // ----------------------------------------
  initial begin
    failures = 0;
    checks = 0;
    cycles = 0;
    rst = 1'b1;
    mode_select_line = 1'b1;
    rate_sel = 2'h0;
    rx_ready = 1'b0;
    tx_data = 8'h00;
    tx_valid = 1'b0;
    err_clr = 1'b0;
    t_normal();
    t_entry();
    t_rates();
    t_fifo();
    t_frame();
    t_single();
    final_report();
  end
endmodule // sfp_prog_entry_tb_top
